/* File: dma_page_pkg.sv */
// Constants, types and shared decode for the DMA page address extender.
// Functional notes
// - Eight channels in two units; secondary channel 4 only cascades primary requests.
// - Channels 0-3 move bytes, blocks up to 64KB anywhere in 16MB.
// - Channels 5-7 move words, blocks up to 128KB anywhere in 16MB.
// - Channels 5-7 only produce even byte addresses, never odd ones.
// - Page registers of channels 0, 1, 2 decode at 0087, 0083, 0081.
// - Page registers of channels 5, 6, 7 decode at 008B, 0089, 008A.
// - Channel 3 page decodes at 0082, refresh page at 008F.
// - Byte channels: page gives A23-A16, controller gives A15-A0.
// - Byte channels: upper byte enable is the inverse of A0.
// - Word channels: page gives A23-A17, word address shifted to A16-A1.
// - Word channels: upper byte enable and A0 both held low.
// - Controller address never carries into the page; transfers wrap inside it.
// - A refresh request is raised once every 15 microseconds.
package dma_page_pkg;

  // ************************************************************
  // I/O map
  // ************************************************************
  localparam logic [15:0] IO_PAGE_CH0     = 16'h0087;
  localparam logic [15:0] IO_PAGE_CH1     = 16'h0083;
  localparam logic [15:0] IO_PAGE_CH2     = 16'h0081;
  localparam logic [15:0] IO_PAGE_CH3     = 16'h0082;
  localparam logic [15:0] IO_PAGE_CH5     = 16'h008B;
  localparam logic [15:0] IO_PAGE_CH6     = 16'h0089;
  localparam logic [15:0] IO_PAGE_CH7     = 16'h008A;
  localparam logic [15:0] IO_PAGE_REFRESH = 16'h008F;
  localparam logic [7:0]  IO_FLOAT_DATA   = 8'hFF;
  localparam logic [7:0]  PAGE_RESET      = 8'h00;

  // Slot of each page register inside the page store.
  localparam logic [2:0] SLOT_CH0     = 3'h0;
  localparam logic [2:0] SLOT_CH1     = 3'h1;
  localparam logic [2:0] SLOT_CH2     = 3'h2;
  localparam logic [2:0] SLOT_CH3     = 3'h3;
  localparam logic [2:0] SLOT_REFRESH = 3'h4;
  localparam logic [2:0] SLOT_CH5     = 3'h5;
  localparam logic [2:0] SLOT_CH6     = 3'h6;
  localparam logic [2:0] SLOT_CH7     = 3'h7;
  localparam int         PAGE_SLOTS   = 8;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int REFRESH_PERIOD_NS = 15000;
  localparam int CLK_PERIOD_NS     = 4;
  localparam int REFRESH_CYCLES    = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] REFRESH_RELOAD = 12'(REFRESH_CYCLES - 1);
  localparam logic [11:0] COUNT_ZERO     = 12'h000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } io_req_t;

  typedef struct packed {
    logic [3:0]  ack;
    logic [15:0] addr;
    logic        hold_req;
  } dma_unit_t;

  typedef struct packed {
    logic        hit;
    logic [2:0]  slot;
  } page_hit_t;

  typedef enum logic [3:0] {
    SRC_IDLE    = 4'b0001,
    SRC_BYTE    = 4'b0010,
    SRC_WORD    = 4'b0100,
    SRC_REFRESH = 4'b1000
  } addr_src_t;

  // Maps an I/O address onto a page register slot.
  function automatic page_hit_t page_decode(input logic [15:0] addr);
    page_hit_t r;
    r = '{hit: 1'b1, slot: SLOT_CH0};
    unique case (addr)
      IO_PAGE_CH0:     r.slot = SLOT_CH0;
      IO_PAGE_CH1:     r.slot = SLOT_CH1;
      IO_PAGE_CH2:     r.slot = SLOT_CH2;
      IO_PAGE_CH3:     r.slot = SLOT_CH3;
      IO_PAGE_CH5:     r.slot = SLOT_CH5;
      IO_PAGE_CH6:     r.slot = SLOT_CH6;
      IO_PAGE_CH7:     r.slot = SLOT_CH7;
      IO_PAGE_REFRESH: r.slot = SLOT_REFRESH;
      default:         r.hit  = 1'b0;
    endcase
    return r;
  endfunction

endpackage

/* File: page_store.sv */
// Eight-entry page register store with two registered read ports.
`timescale 1ns/100ps
`default_nettype none
module page_store
  import dma_page_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_slot,
  input  wire logic [7:0] wr_data,
  // Read ports
  input  wire logic [2:0] rd_a_slot,
  output var  logic [7:0] rd_a_data,
  input  wire logic [2:0] rd_b_slot,
  output var  logic [7:0] rd_b_data
);

  typedef struct packed {
    logic [PAGE_SLOTS-1:0][7:0] page;
    logic [7:0]                 rd_a;
    logic [7:0]                 rd_b;
  } store_state_t;

  store_state_t st_reg;
  store_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.rd_a = st_reg.page[rd_a_slot];
    st_next.rd_b = st_reg.page[rd_b_slot];
    for (int i = 0; i < PAGE_SLOTS; i++) begin
      if (wr_en && (wr_slot == 3'(i))) begin
        st_next.page[i] = wr_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '{page: {PAGE_SLOTS{PAGE_RESET}}, rd_a: PAGE_RESET, rd_b: PAGE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_a_data = st_reg.rd_a;
  assign rd_b_data = st_reg.rd_b;

endmodule
`default_nettype wire

/* File: dma_page_address_extender.sv */
// Page registers, address formation and refresh pacing around two DMA units.
`timescale 1ns/100ps
`default_nettype none
module dma_page_address_extender
  import dma_page_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Processor I/O port
  input  wire io_req_t     io_req,
  output var  logic [7:0]  io_rdata,
  output var  logic        io_rdata_valid,
  // Primary DMA unit, channels 0 to 3
  input  wire dma_unit_t   primary_dma_unit,
  output var  logic        primary_hold_ack,
  // Secondary DMA unit, channels 4 to 7
  input  wire dma_unit_t   secondary_dma_unit,
  output var  logic        cascade_req,
  // Refresh
  input  wire logic        refresh_active,
  input  wire logic [15:0] refresh_addr,
  output var  logic        refresh_req,
  // System address
  output var  logic [23:0] sys_addr,
  output var  logic        upper_byte_enable,
  output var  logic        sys_addr_valid
);

  typedef struct packed {
    addr_src_t   src_p1;
    logic [15:0] low_p1;
    logic        rd_p1;
    logic        rd_hit_p1;
    logic [7:0]  io_rdata;
    logic        io_rdata_valid;
    logic [23:0] sys_addr;
    logic        ube;
    logic        addr_valid;
    logic [11:0] refresh_cnt;
    logic        refresh_req;
    logic        cascade_req;
    logic        hold_ack;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;
  page_hit_t   wr_hit;
  page_hit_t   rd_hit;
  logic [2:0]  own_slot;
  addr_src_t   own_src;
  logic [15:0] own_low;
  logic [7:0]  io_page;
  logic [7:0]  own_page;

  // ************************************************************
  // Page register access
  // ************************************************************
  always_comb begin
    wr_hit = page_decode(io_req.addr);
    rd_hit = page_decode(io_req.addr);
  end

  page_store u_page_store (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .wr_en     (io_req.wr && wr_hit.hit),
    .wr_slot   (wr_hit.slot),
    .wr_data   (io_req.wdata),
    .rd_a_slot (rd_hit.slot),
    .rd_a_data (io_page),
    .rd_b_slot (own_slot),
    .rd_b_data (own_page)
  );

  // ************************************************************
  // Bus owner selection
  // ************************************************************
  // Refresh wins, then word channels, then byte channels; channel 4 is only
  // the cascade grant and never selects a page.
  always_comb begin
    own_src  = SRC_IDLE;
    own_slot = SLOT_CH0;
    own_low  = primary_dma_unit.addr;
    if (refresh_active) begin
      own_src  = SRC_REFRESH;
      own_slot = SLOT_REFRESH;
      own_low  = refresh_addr;
    end else if (secondary_dma_unit.ack[1]) begin
      own_src  = SRC_WORD;
      own_slot = SLOT_CH5;
      own_low  = secondary_dma_unit.addr;
    end else if (secondary_dma_unit.ack[2]) begin
      own_src  = SRC_WORD;
      own_slot = SLOT_CH6;
      own_low  = secondary_dma_unit.addr;
    end else if (secondary_dma_unit.ack[3]) begin
      own_src  = SRC_WORD;
      own_slot = SLOT_CH7;
      own_low  = secondary_dma_unit.addr;
    end else if (primary_dma_unit.ack[0]) begin
      own_src  = SRC_BYTE;
      own_slot = SLOT_CH0;
    end else if (primary_dma_unit.ack[1]) begin
      own_src  = SRC_BYTE;
      own_slot = SLOT_CH1;
    end else if (primary_dma_unit.ack[2]) begin
      own_src  = SRC_BYTE;
      own_slot = SLOT_CH2;
    end else if (primary_dma_unit.ack[3]) begin
      own_src  = SRC_BYTE;
      own_slot = SLOT_CH3;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_next           = st_reg;
    st_next.src_p1    = own_src;
    st_next.low_p1    = own_low;
    st_next.rd_p1     = io_req.rd;
    st_next.rd_hit_p1 = rd_hit.hit;

    // Read answer two edges after the request.
    st_next.io_rdata_valid = st_reg.rd_p1;
    if (st_reg.rd_p1) begin
      st_next.io_rdata = st_reg.rd_hit_p1 ? io_page : IO_FLOAT_DATA;
    end

    // Address formation. The page never sees a carry from the low part.
    st_next.addr_valid = 1'b1;
    unique case (st_reg.src_p1)
      SRC_BYTE, SRC_REFRESH: begin
        st_next.sys_addr = {own_page, st_reg.low_p1};
        st_next.ube      = ~st_reg.low_p1[0];
      end
      SRC_WORD: begin
        // Bit 0 of the page is not used: the word address fills A16-A1.
        st_next.sys_addr = {own_page[7:1], st_reg.low_p1, 1'b0};
        st_next.ube      = 1'b0;
      end
      SRC_IDLE: begin
        st_next.addr_valid = 1'b0;
        st_next.ube        = 1'b0;
      end
      default: begin
        st_next.addr_valid = 1'b0;
        st_next.ube        = 1'b0;
      end
    endcase

    // Refresh pacing.
    st_next.refresh_req = 1'b0;
    if (st_reg.refresh_cnt == COUNT_ZERO) begin
      st_next.refresh_cnt = REFRESH_RELOAD;
      st_next.refresh_req = 1'b1;
    end else begin
      st_next.refresh_cnt = st_reg.refresh_cnt - 12'h001;
    end

    // Cascade of the primary unit through secondary channel 4.
    st_next.cascade_req = primary_dma_unit.hold_req;
    st_next.hold_ack    = secondary_dma_unit.ack[0];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '{src_p1: SRC_IDLE, low_p1: 16'h0000, rd_p1: 1'b0, rd_hit_p1: 1'b0,
                  io_rdata: 8'h00, io_rdata_valid: 1'b0, sys_addr: 24'h000000,
                  ube: 1'b0, addr_valid: 1'b0, refresh_cnt: REFRESH_RELOAD,
                  refresh_req: 1'b0, cascade_req: 1'b0, hold_ack: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign io_rdata          = st_reg.io_rdata;
  assign io_rdata_valid    = st_reg.io_rdata_valid;
  assign sys_addr          = st_reg.sys_addr;
  assign upper_byte_enable = st_reg.ube;
  assign sys_addr_valid    = st_reg.addr_valid;
  assign refresh_req       = st_reg.refresh_req;
  assign cascade_req       = st_reg.cascade_req;
  assign primary_hold_ack  = st_reg.hold_ack;

endmodule
`default_nettype wire

/* File: dma_page_props.sv */
// Port assertions for the DMA page address extender.
`timescale 1ns/100ps
`default_nettype none
module dma_page_props
  import dma_page_pkg::*;
(
  // Clock, reset and processor port
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire io_req_t     io_req,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rdata_valid,
  // Units, refresh and system address
  input wire dma_unit_t   primary_dma_unit,
  input wire logic        primary_hold_ack,
  input wire dma_unit_t   secondary_dma_unit,
  input wire logic        cascade_req,
  input wire logic        refresh_active,
  input wire logic [15:0] refresh_addr,
  input wire logic        refresh_req,
  input wire logic [23:0] sys_addr,
  input wire logic        upper_byte_enable,
  input wire logic        sys_addr_valid
);
  logic [11:0] gap_reg;
  logic        word_c;
  logic        byte_c;
  logic        none_c;
  assign word_c = |secondary_dma_unit.ack[3:1] && !refresh_active;
  assign byte_c = |primary_dma_unit.ack && !(|secondary_dma_unit.ack[3:1]) && !refresh_active;
  assign none_c = !(|primary_dma_unit.ack) && !(|secondary_dma_unit.ack[3:1]) && !refresh_active;
  // Counts cycles since the last refresh request.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= 12'h000;
    end else begin
      gap_reg <= refresh_req ? 12'h000 : gap_reg + 12'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_READ_ANSWER: assert property (io_req.rd |-> ##2 io_rdata_valid)
    else $error("read answer late");
  AST_ANSWER_CAUSE: assert property (io_rdata_valid |-> $past(io_req.rd, 2))
    else $error("read answer without read");
  AST_WORD_EVEN: assert property ($past(word_c, 2) |-> !sys_addr[0] && !upper_byte_enable)
    else $error("word address odd");
  AST_WORD_SHIFT: assert property ($past(word_c, 2) |->
    sys_addr_valid && sys_addr[16:1] == $past(secondary_dma_unit.addr, 2))
    else $error("word address not shifted");
  AST_BYTE_LOW: assert property ($past(byte_c, 2) |->
    sys_addr_valid && sys_addr[15:0] == $past(primary_dma_unit.addr, 2))
    else $error("byte address wrong");
  AST_BYTE_UBE: assert property (sys_addr_valid && !$past(word_c, 2) |->
    upper_byte_enable == !sys_addr[0])
    else $error("upper byte enable wrong");
  AST_REFRESH_LOW: assert property ($past(refresh_active, 2) |->
    sys_addr_valid && sys_addr[15:0] == $past(refresh_addr, 2))
    else $error("refresh address wrong");
  AST_NO_OWNER: assert property ($past(none_c, 2) |->
    !sys_addr_valid && !upper_byte_enable && $stable(sys_addr))
    else $error("address driven without owner");
  AST_CASCADE: assert property (cascade_req == $past(primary_dma_unit.hold_req) &&
    primary_hold_ack == $past(secondary_dma_unit.ack[0]))
    else $error("cascade path wrong");
  AST_REFRESH_PACE: assert property (gap_reg <= 12'hEA6 &&
    (!refresh_req || gap_reg >= 12'hEA5))
    else $error("refresh pace wrong");
  cover property (io_rdata_valid);
  cover property (refresh_req);
  cover property (sys_addr_valid && $past(word_c, 2));
endmodule
bind dma_page_address_extender dma_page_props dma_page_props_inst (.core_clk, .nrst,
  .io_req, .io_rdata, .io_rdata_valid, .primary_dma_unit, .primary_hold_ack,
  .secondary_dma_unit, .cascade_req, .refresh_active, .refresh_addr, .refresh_req,
  .sys_addr, .upper_byte_enable, .sys_addr_valid);
`default_nettype wire

/* File: dma_far_model.sv */
// Behavioural model of the two DMA units facing the extender.
`timescale 1ns/100ps
`default_nettype none
module dma_far_model
  import dma_page_pkg::*;
(
  // Grant command, 8 and above means idle
  input  wire logic [3:0]  grant,
  input  wire logic [15:0] addr,
  input  wire logic        hold,
  // Unit outputs
  output var  dma_unit_t   pri,
  output var  dma_unit_t   sec
);
  // Address lines of an idle unit show the inverse, never the last value.
  always_comb begin
    pri = '0;
    sec = '0;
    pri.hold_req = hold;
    pri.addr = ~addr;
    sec.addr = ~addr;
    if (grant < 4'h4) begin
      pri.ack[grant[1:0]] = 1'b1;
      pri.addr = addr;
    end else if (grant < 4'h8) begin
      sec.ack[grant[1:0]] = 1'b1;
      sec.addr = addr;
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench for the DMA page address extender.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dma_page_pkg::*;
  logic        core_clk, nrst, hold, refresh_active, io_rdata_valid;
  logic        primary_hold_ack, cascade_req, refresh_req, upper_byte_enable, sys_addr_valid;
  logic [3:0]  grant;
  logic [7:0]  io_rdata;
  logic [15:0] dma_addr, refresh_addr;
  logic [23:0] sys_addr;
  io_req_t     io_req;
  dma_unit_t   pri, sec;
  int          error_cnt, checked;
  logic [15:0] pg_addr [8] = '{16'h0087, 16'h0083, 16'h0081, 16'h0082,
                               16'h008F, 16'h008B, 16'h0089, 16'h008A};
  dma_page_address_extender dma_page_address_extender_inst (.core_clk(core_clk), .nrst(nrst),
    .io_req(io_req), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .primary_dma_unit(pri), .primary_hold_ack(primary_hold_ack), .secondary_dma_unit(sec),
    .cascade_req(cascade_req), .refresh_active(refresh_active), .refresh_addr(refresh_addr),
    .refresh_req(refresh_req), .sys_addr(sys_addr), .upper_byte_enable(upper_byte_enable),
    .sys_addr_valid(sys_addr_valid));
  dma_far_model dma_far_model_inst (.grant(grant), .addr(dma_addr), .hold(hold), .pri(pri),
    .sec(sec));
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  function automatic logic [7:0] pv(input int i);
    return 8'h1F + 8'(i) * 8'h20;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk) io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge core_clk) io_req.wr <= 1'b0;
  endtask
  task automatic io_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk) io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge core_clk) io_req.rd <= 1'b0;
    @(posedge core_clk);
    #1 chk(io_rdata_valid, 1'b1);
    chk(io_rdata, exp);
  endtask
  task automatic own(input logic [3:0] g, input logic [15:0] a, input logic r,
                     input logic [23:0] ea, input logic eu, input logic ev);
    @(posedge core_clk) grant <= g;
    dma_addr <= a;
    refresh_active <= r;
    hold <= (g == 4'h4);
    repeat (3) @(posedge core_clk);
    #1 chk(sys_addr_valid, ev);
    chk(sys_addr, ea);
    chk(upper_byte_enable, eu);
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000 error_cnt++;
    complete_run;
  end
  initial begin
    logic [15:0] a;
    logic [7:0]  p;
    int          n;
    io_req = '0; grant = 4'h8; dma_addr = 16'h0000; hold = 1'b0; nrst = 1'b0;
    refresh_active = 1'b0; refresh_addr = 16'h0100; error_cnt = 0; checked = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) io_rd(pg_addr[i], 8'h00);
    io_rd(16'h0080, 8'hFF);
    for (int i = 0; i < 8; i++) io_wr(pg_addr[i], pv(i));
    io_wr(16'h0084, 8'h55);
    for (int i = 0; i < 8; i++) io_rd(pg_addr[i], pv(i));
    for (int i = 0; i < 4; i++) begin
      a = 16'hFFFE + 16'(i);
      own(4'(i), a, 1'b0, {pv(i), a}, ~a[0], 1'b1);
    end
    for (int i = 5; i < 8; i++) begin
      p = pv(i);
      own(4'(i), 16'hFFFF, 1'b0, {p[7:1], 16'hFFFF, 1'b0}, 1'b0, 1'b1);
    end
    own(4'h1, 16'h2222, 1'b1, {pv(4), 16'h0100}, 1'b1, 1'b1);
    chk(cascade_req, 1'b0);
    chk(primary_hold_ack, 1'b0);
    own(4'h4, 16'h3333, 1'b0, {pv(4), 16'h0100}, 1'b0, 1'b0);
    chk(cascade_req, 1'b1);
    chk(primary_hold_ack, 1'b1);
    n = 0;
    while (refresh_req !== 1'b1 && n < 8000) begin
      @(posedge core_clk) n++;
      #1;
    end
    n = 0;
    do begin
      @(posedge core_clk) n++;
      #1;
    end while (refresh_req !== 1'b1 && n < 8000);
    chk(n, 3750);
    complete_run;
  end
endmodule
`default_nettype wire
